// file: src/bst_consts.svh
/*
  Constants of the boundary scan test port: instruction codes,
  register widths and reset values.
  Assumes it is included by bare name wherever these values are used.
*/
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH

// Instruction register width and instruction codes.
`define BST_IR_W 4
`define BST_IR_EXTEST 4'h0
`define BST_IR_SAMPLE 4'h1
`define BST_IR_IDCODE 4'h2
`define BST_IR_BYPASS 4'hF

// Fixed pattern captured into the instruction shifter.
`define BST_IR_CAPTURE 4'h1

// Identification register width and default value (value is arbitrary).
`define BST_ID_W 32
`define BST_IDCODE_DEF 32'h0ABC_D001

// Link clock period in ns and core clock period in ns.
`define BST_TCK_NS 400
`define BST_CLK_NS 50

`endif

// file: src/bst_pkg.sv
/*
  Types of the boundary scan test port: the controller state set.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bst_pkg;

  // The sixteen controller states.
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR,
    ST_EXIT2_IR, ST_UPD_IR
  } bst_state_e;

endpackage : bst_pkg

// file: src/bst_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous levels.
  Assumes the inputs may change at any time relative to i_clk.
*/
`timescale 1ns/1ns
module bst_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bst_sync_s;

  bst_sync_s sync_reg;
  bst_sync_s sync_next;

  // The first stage feeds only the second stage.
  always_comb begin
    sync_next.s1 = i_async;
    sync_next.s2 = sync_reg.s1;
  end

  // Both stages clear on reset.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg.s2;

endmodule : bst_sync

// file: src/bst_tap.sv
/*
  Boundary scan test access port: controller, instruction register,
  bypass, identification and boundary registers.
  Assumes the test clock is at least four core clock periods long and
  that the pin driver combines o_tdo with o_tdo_oe.
  // Overview of operation
  // - Five test pins: mode, clock, in, out, reset.
  // - Inputs sampled on rise, output on fall.
  // - Sixteen-state controller advancing only on clock edges.
  // - Controller routes serial path to selected register.
  // - Four instructions, each selecting its register.
  // - Reset loads the identification instruction.
  // - Identification selects a 32-bit code register.
  // - Bypass is one shift stage.
  // - Sample leaves pin to core paths untouched.
  // - Boundary cells capture pin values in Capture-DR.
  // - Preload moves shifted data into output latches.
  // - Capture shifts out while preload shifts in.
  // - Extest drives latched values onto pins immediately.
  // - Test output floats unless shifting.
*/
`timescale 1ns/1ns
`include "bst_consts.svh"
module bst_tap #(
  parameter int N_IN = 8,
  parameter int N_OUT = 8,
  parameter logic [`BST_ID_W-1:0] IDCODE = `BST_IDCODE_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  output bst_pkg::bst_state_e o_state,
  input wire logic [N_IN-1:0] i_pin_in,
  output logic [N_IN-1:0] o_core_in,
  input wire logic [N_OUT-1:0] i_core_out,
  output logic [N_OUT-1:0] o_pin_out
);
  import bst_pkg::*;

  localparam int BW = N_IN + N_OUT;
  localparam int IRW = `BST_IR_W;

  // Refuse sizes the boundary chain cannot serve.
  if (N_IN < 1 || N_OUT < 1) begin : g_size_check
    $error("bst_tap: N_IN and N_OUT must each be at least one");
  end

  typedef struct packed {
    bst_state_e st;
    logic [IRW-1:0] ir_sh;
    logic [IRW-1:0] ir;
    logic byp;
    logic [`BST_ID_W-1:0] id_sh;
    logic [BW-1:0] bsr_sh;
    logic [N_OUT-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe;
    logic tck_prev;
    logic armed; // Low for one clock after any reset.
  } bst_tap_s;

  bst_tap_s tap_reg;
  bst_tap_s tap_next;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic rise;
  logic fall;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic rst_all_n;

  // Pins from the test controller cross into the core clock here.
  bst_sync #(.W(3)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_tck, i_tms, i_tdi}),
    .o_sync({tck_s, tms_s, tdi_s})
  );

  // Edges of the test clock as seen by the core clock. No edge is taken
  // in the first clock after either reset, so a test clock left high
  // across a test reset is not mistaken for a rise.
  assign rise = tap_reg.armed & tck_s & ~tap_reg.tck_prev;
  assign fall = tap_reg.armed & ~tck_s & tap_reg.tck_prev;

  // Instruction decode; unknown codes fall back to bypass.
  assign sel_bsr = (tap_reg.ir == `BST_IR_EXTEST) ||
                   (tap_reg.ir == `BST_IR_SAMPLE);
  assign sel_id = (tap_reg.ir == `BST_IR_IDCODE);
  assign sel_byp = ~sel_bsr & ~sel_id;

  // Test reset acts without the clock, like the system reset.
  assign rst_all_n = i_rst_n & i_trst_n;

  // Next controller state for a given mode select level.
  function automatic bst_state_e tap_step(bst_state_e s, logic m);
    bst_state_e ns;
    ns = ST_TLR;
    case (s)
      ST_TLR: ns = m ? ST_TLR : ST_RTI;
      ST_RTI: ns = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: ns = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: ns = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: ns = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: ns = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: ns = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: ns = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: ns = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: ns = m ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: ns = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: ns = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: ns = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: ns = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: ns = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: ns = m ? ST_SEL_DR : ST_RTI;
      default: ns = ST_TLR;
    endcase
    return ns;
  endfunction : tap_step

  // Controller, register actions on the rise and output on the fall.
  always_comb begin
    tap_next = tap_reg;
    tap_next.tck_prev = tck_s;
    tap_next.armed = 1'b1;
    if (rise) begin
      tap_next.st = tap_step(tap_reg.st, tms_s);
      case (tap_reg.st)
        ST_CAP_IR: begin
          tap_next.ir_sh = `BST_IR_CAPTURE;
        end
        ST_SHIFT_IR: begin
          tap_next.ir_sh = {tdi_s, tap_reg.ir_sh[IRW-1:1]};
        end
        ST_UPD_IR: begin
          tap_next.ir = tap_reg.ir_sh;
        end
        ST_CAP_DR: begin
          if (sel_bsr) begin
            tap_next.bsr_sh = {i_pin_in, i_core_out};
          end
          if (sel_id) begin
            tap_next.id_sh = IDCODE;
          end
          if (sel_byp) begin
            tap_next.byp = 1'b0;
          end
        end
        ST_SHIFT_DR: begin
          // Captured bits leave while new bits enter.
          if (sel_bsr) begin
            tap_next.bsr_sh = {tdi_s, tap_reg.bsr_sh[BW-1:1]};
          end
          if (sel_id) begin
            tap_next.id_sh = {tdi_s, tap_reg.id_sh[`BST_ID_W-1:1]};
          end
          if (sel_byp) begin
            tap_next.byp = tdi_s;
          end
        end
        ST_UPD_DR: begin
          if (sel_bsr) begin
            tap_next.bsr_upd = tap_reg.bsr_sh[N_OUT-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (fall) begin
      // Drive only while a shift state is in force.
      tap_next.tdo_oe = (tap_reg.st == ST_SHIFT_IR) ||
                        (tap_reg.st == ST_SHIFT_DR);
      if (tap_reg.st == ST_SHIFT_IR) begin
        tap_next.tdo = tap_reg.ir_sh[0];
      end else if (sel_bsr) begin
        tap_next.tdo = tap_reg.bsr_sh[0];
      end else if (sel_id) begin
        tap_next.tdo = tap_reg.id_sh[0];
      end else begin
        tap_next.tdo = tap_reg.byp;
      end
    end
    if (tap_reg.st == ST_TLR) begin
      tap_next.ir = `BST_IR_IDCODE;
    end
  end

  // State register; either reset returns to the reset state.
  always_ff @(posedge i_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      tap_reg <= '{st: ST_TLR, ir_sh: `BST_IR_CAPTURE,
                   ir: `BST_IR_IDCODE, byp: 1'b0, id_sh: '0,
                   bsr_sh: '0, bsr_upd: '0, tdo: 1'b0,
                   tdo_oe: 1'b0, tck_prev: 1'b0,
                   armed: 1'b0};
    end else begin
      tap_reg <= tap_next;
    end
  end

  // Pin to core path always passes straight through; core to pin unless extest is current.
  assign o_core_in = i_pin_in;
  assign o_pin_out = (tap_reg.ir == `BST_IR_EXTEST) ?
                     tap_reg.bsr_upd : i_core_out;
  assign o_tdo = tap_reg.tdo;
  assign o_tdo_oe = tap_reg.tdo_oe;
  assign o_state = tap_reg.st;

  // Count of consecutive test clock rises with mode select high.
  logic [2:0] ones_cnt;
  always_ff @(posedge i_clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      ones_cnt <= 3'h0;
    end else if (rise) begin
      ones_cnt <= !tms_s ? 3'h0 : (ones_cnt == 3'h5) ? 3'h5 :
                  3'(ones_cnt + 3'h1);
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_all_n);

  five_ones_reset_a: assert property (
    ones_cnt == 3'h5 |-> tap_reg.st == ST_TLR)
    else $error("five high mode clocks did not reach reset state");
  reset_ir_load_a: assert property (
    tap_reg.st == ST_TLR |=> tap_reg.ir == `BST_IR_IDCODE)
    else $error("reset state did not load identification code");
  state_hold_a: assert property (
    !rise |=> $stable(tap_reg.st))
    else $error("controller moved without a test clock rise");
  tdo_on_fall_a: assert property (
    !fall |=> $stable(o_tdo) && $stable(o_tdo_oe))
    else $error("test output changed away from a falling edge");
  tdo_float_a: assert property (
    fall && tap_reg.st != ST_SHIFT_DR && tap_reg.st != ST_SHIFT_IR
    |=> !o_tdo_oe)
    else $error("test output driven outside a shift state");
  id_capture_a: assert property (
    rise && tap_reg.st == ST_CAP_DR && sel_id |=> tap_reg.id_sh == IDCODE)
    else $error("identification register not captured");
  bypass_shift_a: assert property (
    rise && tap_reg.st == ST_SHIFT_DR && sel_byp
    |=> tap_reg.byp == $past(tdi_s))
    else $error("bypass stage did not take test data in");
  preload_update_a: assert property (
    rise && tap_reg.st == ST_UPD_DR && sel_bsr
    |=> tap_reg.bsr_upd == $past(tap_reg.bsr_sh[N_OUT-1:0]))
    else $error("output latches did not take shifted data");
  extest_drive_a: assert property (
    rise && tap_reg.st == ST_UPD_IR && tap_reg.ir_sh == `BST_IR_EXTEST
    |=> o_pin_out == tap_reg.bsr_upd)
    else $error("extest did not drive latched values at once");
  sample_pass_a: assert property (
    tap_reg.ir != `BST_IR_EXTEST |-> o_pin_out == i_core_out)
    else $error("functional output disturbed outside extest");

endmodule : bst_tap

// file: verif/bst_ctl_model.sv
/*
  Board test controller model that drives the test port pins.
  Assumes i_tdo is read through a pull-up while the port floats.
*/
`timescale 1ns/1ns
module bst_ctl_model (
  input wire logic i_clk,
  input wire logic i_tdo,
  input wire logic i_tdo_oe,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  // Pins start with the clock low; it stands still, high, between calls.
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end

  // One test clock of eight core clocks; mode and data move at the fall.
  task automatic cyc(input logic tms, input logic tdi);
    o_tck <= 1'b0;
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_clk);
    o_tck <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : cyc

  // Walks n test clocks with the mode bits given LSB first.
  task automatic move(input int n, input logic [7:0] tms);
    for (int i = 0; i < n; i++) begin
      cyc(tms[i], 1'b0);
    end
  endtask : move

  // Shifts n bits LSB first from idle, through update, back to idle.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_ok);
    dout = '0;
    oe_ok = 1'b1;
    move(ir ? 4 : 3, ir ? 8'h03 : 8'h01);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i]);
      dout[i] = i_tdo;
      oe_ok = oe_ok & i_tdo_oe;
    end
    move(2, 8'h01);
    repeat (2) @(posedge i_clk);
  endtask : scan

  // Pulses the test reset pin low for two core clocks.
  task automatic pulse_trst();
    o_trst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    o_trst_n <= 1'b1;
  endtask : pulse_trst
endmodule : bst_ctl_model

// file: verif/bst_tap_tb.sv
/*
  Self-checking bench of the test access port with a controller model.
  Assumes the design files and bst_consts.svh are compiled first.
*/
`timescale 1ns/1ns
`include "bst_consts.svh"
module bst_tap_tb;
  import bst_pkg::*;
  logic i_clk, i_rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, oe_ok;
  bst_state_e state;
  logic [7:0] pin_in, core_in, core_out, pin_out;
  logic [31:0] dout;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  tri1 tdo_pad;

  // The pad floats high whenever the port releases it.
  assign tdo_pad = tdo_oe ? tdo : 1'bz;

  bst_tap #(.N_IN(8), .N_OUT(8)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .o_state(state), .i_pin_in(pin_in),
    .o_core_in(core_in), .i_core_out(core_out), .o_pin_out(pin_out));

  bst_ctl_model ctl (.i_clk(i_clk), .i_tdo(tdo_pad), .i_tdo_oe(tdo_oe),
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));

  // Core clock of 50 ns.
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short well beyond the expected length of the run.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Reads the identification code left selected by reset.
  task automatic t_idcode();
    check("reset state", ST_TLR, state);
    check("oe at reset", 1'b0, tdo_oe);
    ctl.move(1, 8'h00);
    ctl.scan(1'b0, 32, 32'h0, dout, oe_ok);
    check("idcode", `BST_IDCODE_DEF, dout);
    check("oe in shift", 1'b1, oe_ok);
    check("oe after shift", 1'b0, tdo_oe);
    check("idle state", ST_RTI, state);
    $display("test idcode done");
  endtask : t_idcode

  // Bypass and an unused code both give a one-stage path.
  task automatic t_bypass();
    logic [3:0] codes [2] = '{`BST_IR_BYPASS, 4'h5};
    foreach (codes[k]) begin
      ctl.scan(1'b1, 4, {28'h0, codes[k]}, dout, oe_ok);
      check("ir capture", `BST_IR_CAPTURE, dout);
      ctl.scan(1'b0, 8, 32'hA5, dout, oe_ok);
      check("bypass path", 32'h4A, dout);
    end
    $display("test bypass done");
  endtask : t_bypass

  // Samples pins while preloading the output latches.
  task automatic t_sample();
    ctl.scan(1'b1, 4, `BST_IR_SAMPLE, dout, oe_ok);
    ctl.scan(1'b0, 16, 32'h5A, dout, oe_ok);
    check("sample capture", 32'h3C96, dout);
    check("functional paths", 16'h3C96, {core_in, pin_out});
    $display("test sample done");
  endtask : t_sample

  // Extest after preload drives the latched pattern at once.
  task automatic t_extest();
    core_out <= 8'h11;
    ctl.scan(1'b1, 4, `BST_IR_EXTEST, dout, oe_ok);
    check("extest pins", 8'h5A, pin_out);
    ctl.scan(1'b0, 16, 32'hC3, dout, oe_ok);
    check("extest capture", 32'h3C11, dout);
    check("extest update", 8'hC3, pin_out);
    ctl.scan(1'b1, 4, `BST_IR_IDCODE, dout, oe_ok);
    check("pins released", 8'h11, pin_out);
    $display("test extest done");
  endtask : t_extest

  // Test reset in mid-shift, then five ones from the shift state.
  task automatic t_reset();
    ctl.scan(1'b1, 4, `BST_IR_EXTEST, dout, oe_ok);
    ctl.move(3, 8'h01);
    repeat (2) @(posedge i_clk);
    check("shift state", ST_SHIFT_DR, state);
    ctl.pulse_trst();
    repeat (2) @(posedge i_clk);
    check("trst state", ST_TLR, state);
    check("trst pins", 8'h11, pin_out);
    // Walk into the data shift state so no instruction is updated.
    ctl.move(5, 8'h02);
    ctl.move(5, 8'h1F);
    repeat (2) @(posedge i_clk);
    check("five ones", ST_TLR, state);
    $display("test reset done");
  endtask : t_reset

  // Main sequence.
  initial begin
    i_rst_n = 1'b0;
    pin_in = 8'h3C;
    core_out = 8'h96;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_reset();
    report_and_stop();
  end
endmodule : bst_tap_tb
